// ### rtl/pump_run_supervisor_defines.vh
`ifndef PUMP_RUN_SUPERVISOR_DEFINES_VH
`define PUMP_RUN_SUPERVISOR_DEFINES_VH

// Clock and time base
`define CLK_HZ            20000000
`define SEC_CYCLES        (`CLK_HZ / 1)

// Restart delay times, minutes as set and seconds as counted
`define DELAY_DEF_MIN     3
`define DELAY_MID_MIN     10
`define DELAY_LONG_MIN    30
`define DELAY_CAP_MIN     14
`define OC_OFF_MIN        3
`define DELAY_DEF_S       (`DELAY_DEF_MIN * 60)
`define DELAY_MID_S       (`DELAY_MID_MIN * 60)
`define DELAY_LONG_S      (`DELAY_LONG_MIN * 60)
`define DELAY_CAP_S       (`DELAY_CAP_MIN * 60)
`define OC_OFF_S          (`OC_OFF_MIN * 60)
`define SEC_W             11

// Low-power check is blind this long after each start
`define LP_GRACE_S        5
// Seconds each screen stays up while cycling
`define DISP_STEP_S       4

// Switch positions (bit index into the switch bank)
`define SW_REMOTE_POL     0
`define SW_PROBE_POL      1
`define SW_DELAY_MID      2
`define SW_DELAY_LONG     3
`define SW_FREEZE         6

// Screen codes
`define SCR_SPLASH        3'h0
`define SCR_STATUS        3'h1
`define SCR_BUS           3'h2
`define SCR_SPEED         3'h3
`define SCR_DUTY          3'h4
`define SCR_POWER         3'h5

// Message codes on the status screen
`define MSG_NONE          2'h0
`define MSG_OVERCURRENT   2'h1
`define MSG_LOW_POWER     2'h2
`define MSG_REMOTE_HALT   2'h3

// Register byte offsets
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_HOLD_EXT      4'h8
`define REG_REMAIN        4'hC

// Register fields and reset values
`define CTRL_RUN_EN_BIT   0
`define CTRL_RESET        1'h1
`define HOLD_EXT_W        10
`define HOLD_EXT_RESET    10'h000

`endif

// ### rtl/sec_countdown.v
`include "pump_run_supervisor_defines.vh"

module sec_countdown (
  // Clock and reset
  input  wire              i_clk,
  input  wire              i_arst_n,
  // Control
  input  wire              i_tick,
  input  wire              i_load,
  input  wire [`SEC_W-1:0] i_value,
  // State
  output reg               o_busy,
  output reg  [`SEC_W-1:0] o_remain
);

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_remain <= {`SEC_W{1'b0}};
      o_busy   <= 1'b0;
    end else if (i_load) begin
      o_remain <= i_value;
      o_busy   <= (i_value != {`SEC_W{1'b0}});
    end else if (i_tick && o_busy) begin
      o_remain <= o_remain - {{(`SEC_W-1){1'b0}}, 1'b1};
      o_busy   <= (o_remain != {{(`SEC_W-1){1'b0}}, 1'b1});
    end
  end

endmodule

// ### rtl/pump_run_supervisor.v
`include "pump_run_supervisor_defines.vh"

module pump_run_supervisor #(
  parameter SEC_CYCLES = `SEC_CYCLES
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_arst_n,
  // Avalon-MM slave
  input  wire [3:0]  i_address,
  input  wire        i_read,
  input  wire        i_write,
  input  wire [3:0]  i_byteenable,
  input  wire [31:0] i_writedata,
  output reg  [31:0] o_readdata,
  output reg         o_waitrequest,
  // Switches and terminals
  input  wire [7:0]  i_dip,
  input  wire        i_remote_sense_terminal_n,
  input  wire        i_water_probe_terminal_n,
  // Power stage measurements, low-power setpoint, duty command and duty maximum
  input  wire        i_overcurrent,
  input  wire [11:0] i_motor_power,
  input  wire [11:0] i_low_power_setpoint_knob,
  input  wire [7:0]  i_duty_cmd,
  input  wire [7:0]  i_duty_max,
  // Drive
  output reg         o_motor_en,
  output reg  [7:0]  o_duty,
  // Indicators and display
  output reg         o_run_led,
  output reg         o_remote_halt_indicator,
  output reg         o_low_output_shutdown_led,
  output reg         o_overcurrent_led,
  output reg  [2:0]  o_screen,
  output reg  [1:0]  o_message
);

  // Constants held at 32 bits, then cut to the width of their use
  localparam [31:0]       SEC_LAST_W   = SEC_CYCLES - 1;
  localparam [31:0]       LP_GRACE_W   = `LP_GRACE_S;
  localparam [31:0]       DISP_STEP_W  = `DISP_STEP_S;
  localparam [31:0]       DELAY_DEF_W  = `DELAY_DEF_S;
  localparam [31:0]       DELAY_MID_W  = `DELAY_MID_S;
  localparam [31:0]       DELAY_LONG_W = `DELAY_LONG_S;
  localparam [31:0]       DELAY_CAP_W  = `DELAY_CAP_S;
  localparam [31:0]       OC_OFF_W     = `OC_OFF_S;
  localparam [24:0]       SEC_LAST     = SEC_LAST_W[24:0];
  localparam [2:0]        LP_GRACE     = LP_GRACE_W[2:0];
  localparam [2:0]        DISP_STEP    = DISP_STEP_W[2:0];
  localparam [`SEC_W-1:0] DELAY_DEF    = DELAY_DEF_W[`SEC_W-1:0];
  localparam [`SEC_W-1:0] DELAY_MID    = DELAY_MID_W[`SEC_W-1:0];
  localparam [`SEC_W-1:0] DELAY_LONG   = DELAY_LONG_W[`SEC_W-1:0];
  localparam [`SEC_W-1:0] DELAY_CAP    = DELAY_CAP_W[`SEC_W-1:0];
  localparam [`SEC_W-1:0] OC_OFF       = OC_OFF_W[`SEC_W-1:0];

  reg  [24:0]           div_q;
  reg                   tick_q;
  reg                   run_en_q;
  reg  [`HOLD_EXT_W-1:0] hold_ext_q;
  reg                   lp_latch_q;
  reg  [2:0]            grace_q;
  reg                   started_q;
  reg                   splash_q;
  reg  [2:0]            disp_cnt_q;
  reg  [`SEC_W-1:0]     base_s;
  reg  [`SEC_W-1:0]     lim_s;
  reg  [`SEC_W:0]       sum_s;
  reg  [`SEC_W-1:0]     delay_s;
  reg  [31:0]           rd_mux;
  reg  [7:0]            duty_d;
  wire                  remote_grounded;
  wire                  probe_grounded;
  wire                  remote_stop;
  wire                  probe_stop;
  wire                  ext_stop;
  wire                  rs_busy;
  wire [`SEC_W-1:0]     rs_remain;
  wire                  oc_busy;
  wire [`SEC_W-1:0]     oc_remain;
  wire                  oc_trip;
  wire                  lp_trip;
  wire                  rs_hold;
  wire                  run_d;
  wire                  freeze;
  wire                  req;

  // One-second enable
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q  <= 25'h0000000;
      tick_q <= 1'b0;
    end else if (div_q == SEC_LAST) begin
      div_q  <= 25'h0000000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 25'h0000001;
      tick_q <= 1'b0;
    end
  end

  assign remote_grounded = ~i_remote_sense_terminal_n;
  assign probe_grounded  = ~i_water_probe_terminal_n;
  assign remote_stop = i_dip[`SW_REMOTE_POL] ? ~remote_grounded : remote_grounded;
  assign probe_stop  = i_dip[`SW_PROBE_POL] ? ~probe_grounded : probe_grounded;
  assign ext_stop    = remote_stop | probe_stop;

  // Delay length from switches and extension
  always @* begin
    if (i_dip[`SW_DELAY_LONG]) begin
      base_s = DELAY_LONG;
    end else if (i_dip[`SW_DELAY_MID]) begin
      base_s = DELAY_MID;
    end else begin
      base_s = DELAY_DEF;
    end
    lim_s   = (base_s > DELAY_CAP) ? base_s : DELAY_CAP;
    sum_s   = {1'b0, base_s} + {{(`SEC_W+1-`HOLD_EXT_W){1'b0}}, hold_ext_q};
    delay_s = (sum_s > {1'b0, lim_s}) ? lim_s : sum_s[`SEC_W-1:0];
  end

  // reload while stopped, count after clear
  sec_countdown u_rs_delay (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_tick   (tick_q),
    .i_load   (ext_stop),
    .i_value  (delay_s),
    .o_busy   (rs_busy),
    .o_remain (rs_remain)
  );

  // hold until clear and delay expired
  assign rs_hold = ext_stop | rs_busy;

  assign oc_trip = i_overcurrent & o_motor_en;

  sec_countdown u_oc_off (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_tick   (tick_q),
    .i_load   (oc_trip),
    .i_value  (OC_OFF),
    .o_busy   (oc_busy),
    .o_remain (oc_remain)
  );

  // low output power check after grace
  assign lp_trip = o_motor_en & (grace_q == LP_GRACE) &
                   (i_motor_power < i_low_power_setpoint_knob);

  assign run_d = run_en_q & ~rs_hold & ~oc_busy & ~oc_trip & ~lp_latch_q & ~lp_trip;

  // duty capped by peak power maximum
  always @* begin
    if (!run_d) begin
      duty_d = 8'h00;
    end else if (i_duty_cmd > i_duty_max) begin
      duty_d = i_duty_max;
    end else begin
      duty_d = i_duty_cmd;
    end
  end

  // Drive, latch and indicators
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_motor_en                <= 1'b0;
      o_duty                    <= 8'h00;
      o_run_led                 <= 1'b0;
      o_remote_halt_indicator   <= 1'b0;
      o_low_output_shutdown_led <= 1'b0;
      o_overcurrent_led         <= 1'b0;
      o_message                 <= `MSG_NONE;
      lp_latch_q                <= 1'b0;
      grace_q                   <= 3'h0;
    end else begin
      o_motor_en <= run_d;
      o_duty     <= duty_d;
      o_run_led  <= run_d;
      if (lp_trip) begin
        lp_latch_q <= 1'b1;
      end
      if (!o_motor_en) begin
        grace_q <= 3'h0;
      end else if (tick_q && grace_q != LP_GRACE) begin
        grace_q <= grace_q + 3'h1;
      end
      o_remote_halt_indicator   <= rs_hold;
      o_low_output_shutdown_led <= lp_latch_q | lp_trip;
      o_overcurrent_led <= oc_busy | oc_trip;
      if (oc_busy || oc_trip) begin
        o_message <= `MSG_OVERCURRENT;
      end else if (lp_latch_q || lp_trip) begin
        o_message <= `MSG_LOW_POWER;
      end else if (rs_hold) begin
        o_message <= `MSG_REMOTE_HALT;
      end else begin
        o_message <= `MSG_NONE;
      end
    end
  end

  assign freeze = i_dip[`SW_FREEZE];

  // Display sequencing
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      started_q  <= 1'b0;
      splash_q   <= 1'b1;
      disp_cnt_q <= 3'h0;
      o_screen   <= `SCR_SPLASH;
    end else if (!started_q) begin
      // freeze switch caught after reset release
      started_q <= 1'b1;
      splash_q  <= freeze;
      o_screen  <= freeze ? `SCR_SPLASH : `SCR_STATUS;
    end else if (splash_q) begin
      if (!freeze) begin
        splash_q   <= 1'b0;
        disp_cnt_q <= 3'h0;
        o_screen   <= `SCR_STATUS;
      end
    end else if (!freeze && tick_q) begin
      if (disp_cnt_q == DISP_STEP - 3'h1) begin
        disp_cnt_q <= 3'h0;
        o_screen   <= (o_screen == `SCR_POWER) ? `SCR_STATUS : o_screen + 3'h1;
      end else begin
        disp_cnt_q <= disp_cnt_q + 3'h1;
      end
    end
  end

  // Register read data
  always @* begin
    rd_mux = 32'h00000000;
    if (i_address[1:0] == 2'h0) begin
      case ({i_address[3:2], 2'h0})
        `REG_CTRL: begin
          rd_mux[`CTRL_RUN_EN_BIT] = run_en_q;
        end
        `REG_STATUS: begin
          rd_mux[7:0] = {2'h0, lp_latch_q, oc_busy, rs_hold, probe_stop, remote_stop, o_motor_en};
        end
        `REG_HOLD_EXT: begin
          rd_mux[`HOLD_EXT_W-1:0] = hold_ext_q;
        end
        `REG_REMAIN: begin
          rd_mux = {5'h00, oc_remain, 5'h00, rs_remain};
        end
        default: begin
          rd_mux = 32'h00000000;
        end
      endcase
    end
  end

  assign req = i_read | i_write;

  // Avalon slave: one wait cycle, write lands on the release edge
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_waitrequest <= 1'b1;
      o_readdata    <= 32'h00000000;
      run_en_q      <= `CTRL_RESET;
      hold_ext_q    <= `HOLD_EXT_RESET;
    end else if (req && o_waitrequest) begin
      o_waitrequest <= 1'b0;
      o_readdata    <= rd_mux;
    end else begin
      o_waitrequest <= 1'b1;
      if (i_write && !o_waitrequest && i_address[1:0] == 2'h0) begin
        if ({i_address[3:2], 2'h0} == `REG_CTRL && i_byteenable[0]) begin
          run_en_q <= i_writedata[`CTRL_RUN_EN_BIT];
        end
        if ({i_address[3:2], 2'h0} == `REG_HOLD_EXT) begin
          if (i_byteenable[0]) begin
            hold_ext_q[7:0] <= i_writedata[7:0];
          end
          if (i_byteenable[1]) begin
            hold_ext_q[`HOLD_EXT_W-1:8] <= i_writedata[`HOLD_EXT_W-1:8];
          end
        end
      end
    end
  end

endmodule

// ### testbench/pump_run_supervisor_sva.sv
module pump_run_supervisor_sva (
  // Clock and reset
  input logic       i_clk,
  input logic       i_arst_n,
  // Watched inputs
  input logic [7:0] i_dip,
  input logic       i_remote_sense_terminal_n,
  input logic       i_water_probe_terminal_n,
  input logic       i_overcurrent,
  input logic [7:0] i_duty_max,
  // Watched outputs
  input logic       o_motor_en,
  input logic [7:0] o_duty,
  input logic       o_run_led,
  input logic       o_remote_halt_indicator,
  input logic       o_low_output_shutdown_led,
  input logic       o_overcurrent_led,
  input logic [2:0] o_screen,
  input logic [1:0] o_message
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire rem_stop = i_dip[0] ? i_remote_sense_terminal_n : !i_remote_sense_terminal_n;
  wire prb_stop = i_dip[1] ? i_water_probe_terminal_n : !i_water_probe_terminal_n;
  sequence freeze_held;
    i_dip[6] ##1 i_dip[6];
  endsequence
  sequence oc_trip;
    o_motor_en && i_overcurrent;
  endsequence
  a_oc_drive_off: assert property (oc_trip |=> !o_motor_en && o_overcurrent_led)
    else $error("drive stayed on after over-current");
  a_oc_message: assert property (o_overcurrent_led |-> o_message == 2'h1)
    else $error("over-current message missing");
  a_remote_stop: assert property (rem_stop |=> !o_motor_en && o_remote_halt_indicator)
    else $error("remote stop ignored");
  a_probe_stop: assert property (prb_stop |=> !o_motor_en && o_remote_halt_indicator)
    else $error("probe stop ignored");
  a_low_power_latch: assert property (o_low_output_shutdown_led |=> o_low_output_shutdown_led && !o_motor_en)
    else $error("low-power latch released");
  a_duty_cap: assert property (o_duty <= $past(i_duty_max))
    else $error("duty above maximum");
  a_duty_idle: assert property (!o_motor_en |-> o_duty == 8'h00 && !o_run_led)
    else $error("duty or run led while stopped");
  a_screen_freeze: assert property (freeze_held |-> $stable(o_screen))
    else $error("screen moved while frozen");
endmodule

bind pump_run_supervisor pump_run_supervisor_sva u_sva (.i_clk, .i_arst_n, .i_dip, .i_remote_sense_terminal_n,
  .i_water_probe_terminal_n, .i_overcurrent, .i_duty_max, .o_motor_en, .o_duty, .o_run_led,
  .o_remote_halt_indicator, .o_low_output_shutdown_led, .o_overcurrent_led, .o_screen, .o_message);

// ### testbench/pump_far_side.sv
module pump_far_side (
  // Clock
  input  logic        i_clk,
  // Drive from the block
  input  logic        i_motor_en,
  input  logic [7:0]  i_duty,
  // Bench command: pump runs dry
  input  logic        i_stall,
  // Measured output power
  output logic [11:0] o_motor_power
);
  timeunit 1ns;
  timeprecision 1ns;
  // A stopped or dry pump draws no power
  always @(posedge i_clk) o_motor_power <= (i_motor_en && !i_stall) ? {i_duty, 4'h0} : 12'h000;
endmodule

// ### testbench/pump_run_supervisor_test.sv
module pump_run_supervisor_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int S = 2;
  logic        i_clk = 0, i_arst_n = 0, i_read = 0, i_write = 0, i_overcurrent = 0, stall = 0;
  logic        rem_n = 1, prb_n = 1, o_waitrequest, o_motor_en, o_run_led, o_rhi, o_lpl, o_ocl;
  logic [3:0]  i_address = 0;
  logic [7:0]  i_dip = 0, i_duty_cmd = 8'h50, o_duty;
  logic [31:0] i_writedata = 0, o_readdata;
  logic [11:0] power;
  logic [2:0]  o_screen;
  logic [1:0]  o_message;
  int          num_errors = 0, cmp_count = 0, cyc = 0;
  pump_run_supervisor #(.SEC_CYCLES(S)) u_pump_run_supervisor (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_byteenable(4'hF), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_dip(i_dip), .i_remote_sense_terminal_n(rem_n),
    .i_water_probe_terminal_n(prb_n), .i_overcurrent(i_overcurrent), .i_motor_power(power),
    .i_low_power_setpoint_knob(12'h100), .i_duty_cmd(i_duty_cmd), .i_duty_max(8'h40), .o_motor_en(o_motor_en),
    .o_duty(o_duty), .o_run_led(o_run_led), .o_remote_halt_indicator(o_rhi), .o_low_output_shutdown_led(o_lpl),
    .o_overcurrent_led(o_ocl), .o_screen(o_screen), .o_message(o_message));
  pump_far_side u_pump_far_side (.i_clk(i_clk), .i_motor_en(o_motor_en), .i_duty(o_duty), .i_stall(stall),
    .o_motor_power(power));
  initial forever #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    i_read <= !wr;
    i_write <= wr;
    i_address <= a;
    i_writedata <= d;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic wait_run(output int n);
    n = 0;
    while (o_motor_en !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic t_regs;
    logic [31:0] q;
    bus(0, 4'h0, 0, q);
    chk("ctrl", 32'h1, q);
    bus(0, 4'h8, 0, q);
    chk("hold_ext", 32'h0, q);
    bus(1, 4'h8, 32'hFFFF_FFFF, q);
    bus(0, 4'h8, 0, q);
    chk("hold_ext", 32'h3FF, q);
    bus(1, 4'h8, 0, q);
    bus(0, 4'h2, 0, q);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_delay;
    int exp_s[4] = '{180, 600, 1800, 1800};
    int n;
    for (int k = 0; k < 4; k++) begin
      i_dip <= {4'h0, k[1], k[0], k[0], k[1]};
      rem_n <= !k[1];
      prb_n <= !k[0];
      wait_run(n);
      tick(1);
      if (k[0]) prb_n <= k[0];
      else rem_n <= k[1];
      tick(3);
      chk("motor_en", 0, o_motor_en);
      chk("halt_led", 1, o_rhi);
      chk("message", 3, o_message);
      tick(10);
      rem_n <= !k[1];
      prb_n <= !k[0];
      wait_run(n);
      chk_rng("delay", exp_s[k] * S - S, exp_s[k] * S + S + 3, n);
      tick(2);
      chk("halt_led", 0, o_rhi);
    end
  endtask
  task automatic t_ext;
    logic [31:0] q;
    int n;
    bus(1, 4'h8, 32'h3FF, q);
    i_dip <= 8'h00;
    tick(3);
    rem_n <= 1'b1;
    prb_n <= 1'b1;
    tick(100);
    rem_n <= 1'b0;
    tick(2);
    rem_n <= 1'b1;
    wait_run(n);
    chk_rng("capped_delay", 840 * S - S, 840 * S + S + 3, n);
    bus(1, 4'h8, 0, q);
  endtask
  task automatic t_cap;
    tick(2);
    chk("duty", 32'h40, o_duty);
    i_duty_cmd <= 8'h30;
    tick(3);
    chk("duty", 32'h30, o_duty);
    i_duty_cmd <= 8'h50;
  endtask
  task automatic t_oc;
    logic [31:0] q;
    int n;
    i_overcurrent <= 1'b1;
    tick(3);
    chk("motor_en", 0, o_motor_en);
    chk("oc_led", 1, o_ocl);
    wait_run(n);
    chk_rng("oc_off", 180 * S - S, 180 * S + S + 3, n);
    tick(3);
    chk("motor_en", 0, o_motor_en);
    bus(0, 4'h4, 0, q);
    chk("status", 32'h10, q);
    bus(0, 4'hC, 0, q);
    chk_rng("oc_remain", 176, 180, q[26:16]);
    chk("rs_remain", 32'h0, {21'h000000, q[10:0]});
    i_overcurrent <= 1'b0;
    wait_run(n);
    tick(2);
    chk("oc_led", 0, o_ocl);
  endtask
  task automatic t_disp;
    logic [2:0] s;
    int n;
    s = o_screen;
    for (int i = 0; i < 7; i++) begin
      n = 0;
      while (o_screen === s && n < 100) begin
        tick(1);
        n++;
      end
      chk("screen", (s == 3'h5) ? 3'h1 : s + 3'h1, o_screen);
      if (i > 0) chk_rng("step", 4 * S - 1, 4 * S + 1, n);
      s = o_screen;
    end
    i_dip[6] <= 1'b1;
    tick(2);
    s = o_screen;
    tick(30);
    chk("frozen", s, o_screen);
    i_arst_n <= 1'b0;
    tick(3);
    i_arst_n <= 1'b1;
    tick(30);
    chk("splash", 0, o_screen);
    i_dip[6] <= 1'b0;
    tick(3);
    chk("status", 1, o_screen);
  endtask
  task automatic t_lp;
    int n;
    wait_run(n);
    tick(20);
    stall <= 1'b1;
    tick(5);
    chk("lp_led", 1, o_lpl);
    chk("message", 2, o_message);
    stall <= 1'b0;
    tick(20);
    chk("lp_led", 1, o_lpl);
    chk("motor_en", 0, o_motor_en);
  endtask
  task automatic results;
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    tick(3);
    i_arst_n <= 1'b1;
    t_regs();
    t_delay();
    t_ext();
    t_cap();
    t_oc();
    t_disp();
    t_lp();
    results();
  end
endmodule
